// ---- nand_host.sv ----
// nand bus host controller with its program data fifo
`timescale 1ns/100ps
// What this block does
// - bytes latched on write strobe rising edge
// - host drives io only for input cycles
// - byte mode: 12 column, 18 row bits
// - word mode: 11 column, upper byte low
// - unused address bits driven low
// - latch inputs decode cycle kind
// - only defined opcodes are ever issued

// *****************************************************
// fifo
// *****************************************************
module nand_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_valid,   // fill side
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,   // drain side
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];   // storage
  logic [AW-1:0] wp_r, wp_nxt;    // write pointer
  logic [AW-1:0] rp_r, rp_nxt;    // read pointer
  logic [AW:0]   cnt_r, cnt_nxt;  // fill level
  logic          push, pop;
  assign o_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem_r[rp_r];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  // pointers wrap at depth, which need not be a power of two
  always_comb begin
    wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // storage has no reset; words are read only after being written
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_data;
    end
  end
endmodule // nand_fifo

// *****************************************************
// controller
// *****************************************************
module nand_host import nand_host_pkg::*; #(
  parameter int IO_W = 8   // 8 for byte bus, 16 for word bus
) (
  input  wire logic            i_clk,
  input  wire logic            i_reset,
  input  wire logic            i_cmd_valid,   // operation request
  output logic                 o_cmd_ready,
  input  wire cmd_s            i_cmd,
  output logic                 o_done,        // operation finished
  input  wire logic            i_wr_valid,    // program data in
  output logic                 o_wr_ready,
  input  wire logic [IO_W-1:0] i_wr_data,
  output logic                 o_rd_valid,    // read data out
  output logic [IO_W-1:0]      o_rd_data,
  output logic                 o_ce_n,        // chip select
  output logic                 o_cle,         // command latch
  output logic                 o_ale,         // address latch
  output logic                 o_we_n,        // write strobe
  output logic                 o_read_strobe_n,
  output logic                 o_wp_n,        // write protect
  output logic [IO_W-1:0]      o_io_out,
  output logic                 o_io_oe,       // high while host drives
  input  wire logic [IO_W-1:0] i_io_in,
  input  wire logic            i_ready_busy_n
);
  typedef enum {
    S_IDLE, S_CMD1, S_ADDR, S_WFETCH, S_WDATA, S_CMD2,
    S_WB, S_BUSY, S_GAP, S_RDATA, S_DONE
  } state_e;

  localparam logic WIDE = (IO_W == 16);

  state_e          state_r, state_nxt;
  cmd_s            cmd_r, cmd_nxt;       // operation in progress
  logic [7:0]      cnt_r, cnt_nxt;       // phase timer, counts down
  logic            ph_r, ph_nxt;         // 0 strobe low, 1 strobe high
  logic [2:0]      idx_r, idx_nxt;       // address cycle index
  logic [11:0]     len_r, len_nxt;       // words left
  logic            ce_n_r, ce_n_nxt;
  logic            cle_r, cle_nxt;
  logic            ale_r, ale_nxt;
  logic            we_n_r, we_n_nxt;
  logic            re_n_r, re_n_nxt;
  logic            wp_n_r, wp_n_nxt;
  logic            oe_r, oe_nxt;
  logic [IO_W-1:0] io_r, io_nxt;
  logic [IO_W-1:0] rd_r, rd_nxt;
  logic            rdv_r, rdv_nxt;
  logic            done_r, done_nxt;
  logic            rb_s1_r, rb_s2_r;     // ready/busy synchroniser
  logic [IO_W-1:0] io_s1_r, io_s2_r;     // return data synchroniser
  logic            fifo_valid;
  logic [IO_W-1:0] fifo_data;
  logic            fifo_pop;
  logic            wcyc_done;            // write strobe cycle over
  logic            tmr_zero;

  assign tmr_zero  = (cnt_r == 8'h00);
  assign wcyc_done = ph_r && tmr_zero;
  assign fifo_pop  = (state_r == S_WFETCH);
  assign o_cmd_ready = (state_r == S_IDLE);

  nand_fifo #(.W(IO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_valid (i_wr_valid),
    .o_ready (o_wr_ready),
    .i_data  (i_wr_data),
    .o_valid (fifo_valid),
    .i_ready (fifo_pop),
    .o_data  (fifo_data)
  );

  // address byte for cycle k; unused positions are zero
  function automatic logic [7:0] addr_byte(input cmd_s c,
                                           input logic [2:0] k);
    logic [7:0] b;
    b = 8'h00;
    if (c.op == OP_READ_ID) begin
      b = ID_ADDR;
    end else begin
      unique case (k)
        3'h0: b = c.col[7:0];
        3'h1: b = WIDE ? {5'h00, c.col[10:8]}
                       : {4'h0, c.col[11:8]};
        3'h2: b = c.row[7:0];     // plane select rides in bit 6
        3'h3: b = c.row[15:8];
        default: b = {6'h00, c.row[17:16]};
      endcase
    end
    return b;
  endfunction

  // *****************************************************
  // sequencer
  // *****************************************************
  // one always_comb holds the whole pin sequence; the opcodes come
  // only from the package constants, so nothing undefined goes out
  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    cnt_nxt   = tmr_zero ? cnt_r : cnt_r - 8'h01;
    ph_nxt    = ph_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    ce_n_nxt  = ce_n_r;
    cle_nxt   = cle_r;
    ale_nxt   = ale_r;
    we_n_nxt  = we_n_r;
    re_n_nxt  = re_n_r;
    wp_n_nxt  = wp_n_r;
    oe_nxt    = oe_r;
    io_nxt    = io_r;
    rd_nxt    = rd_r;
    rdv_nxt   = 1'b0;
    done_nxt  = 1'b0;
    // end of low half of any write cycle: rising edge latches
    if (!ph_r && tmr_zero && !we_n_r) begin
      we_n_nxt = 1'b1;
      ph_nxt   = 1'b1;
      cnt_nxt  = STROBE_CYC - 8'h01;
    end
    unique case (state_r)
      S_IDLE: begin
        if (i_cmd_valid) begin
          cmd_nxt  = i_cmd;
          ce_n_nxt = 1'b0;
          // protect stays on unless the array is written
          wp_n_nxt = (i_cmd.op == OP_PROGRAM) || (i_cmd.op == OP_ERASE);
          len_nxt  = (i_cmd.op == OP_READ_ID) ? ID_LEN
                   : (i_cmd.op == OP_STATUS) ? STATUS_LEN : i_cmd.len;
          idx_nxt  = (i_cmd.op == OP_ERASE) ? ROW_FIRST : ADDR_FIRST;
          // plain openers only: no random data moves, no copy-back and
          // nothing outside the defined set is ever sent
          unique case (i_cmd.op)
            OP_PAGE_READ: io_nxt = IO_W'(OPC_READ1);
            OP_PROGRAM:   io_nxt = IO_W'(OPC_PROG1);
            OP_ERASE:     io_nxt = IO_W'(OPC_ERASE1);
            OP_STATUS:    io_nxt = IO_W'(OPC_STATUS);
            OP_READ_ID:   io_nxt = IO_W'(OPC_READ_ID);
            OP_RESET:     io_nxt = IO_W'(OPC_RESET);
          endcase
          cle_nxt   = 1'b1;
          ale_nxt   = 1'b0;
          oe_nxt    = 1'b1;
          we_n_nxt  = 1'b0;
          ph_nxt    = 1'b0;
          cnt_nxt   = STROBE_CYC - 8'h01;
          state_nxt = S_CMD1;
        end
      end
      S_CMD1, S_ADDR: begin
        if (wcyc_done) begin
          if (state_r == S_ADDR && (idx_r == ADDR_LAST ||
              cmd_r.op == OP_READ_ID)) begin
            // address complete
            cle_nxt = 1'b0;
            ale_nxt = 1'b0;
            if (cmd_r.op == OP_PROGRAM) begin
              state_nxt = S_WFETCH;
            end else if (cmd_r.op == OP_READ_ID) begin
              oe_nxt    = 1'b0;
              cnt_nxt   = WHR_CYC - 8'h01;
              state_nxt = S_GAP;
            end else begin
              cle_nxt   = 1'b1;
              io_nxt    = (cmd_r.op == OP_ERASE) ? IO_W'(OPC_ERASE2)
                                                 : IO_W'(OPC_READ2);
              we_n_nxt  = 1'b0;
              ph_nxt    = 1'b0;
              cnt_nxt   = STROBE_CYC - 8'h01;
              state_nxt = S_CMD2;
            end
          end else if (state_r == S_CMD1 && (cmd_r.op == OP_STATUS ||
                       cmd_r.op == OP_RESET)) begin
            cle_nxt = 1'b0;
            if (cmd_r.op == OP_STATUS) begin
              oe_nxt    = 1'b0;
              cnt_nxt   = WHR_CYC - 8'h01;
              state_nxt = S_GAP;
            end else begin
              oe_nxt    = 1'b0;
              cnt_nxt   = WB_CYC - 8'h01;
              state_nxt = S_WB;
            end
          end else begin
            // next address cycle
            if (state_r == S_ADDR) begin
              idx_nxt = idx_r + 3'h1;
            end
            cle_nxt   = 1'b0;
            ale_nxt   = 1'b1;
            io_nxt    = IO_W'(addr_byte(cmd_r,
                          (state_r == S_ADDR) ? idx_r + 3'h1 : idx_r));
            we_n_nxt  = 1'b0;
            ph_nxt    = 1'b0;
            cnt_nxt   = STROBE_CYC - 8'h01;
            state_nxt = S_ADDR;
          end
        end
      end
      S_WFETCH: begin
        // stalls here while the fifo is empty
        if (fifo_valid) begin
          io_nxt    = fifo_data;     // both latches low: data input
          we_n_nxt  = 1'b0;
          ph_nxt    = 1'b0;
          cnt_nxt   = STROBE_CYC - 8'h01;
          state_nxt = S_WDATA;
        end
      end
      S_WDATA: begin
        if (wcyc_done) begin
          len_nxt = len_r - 12'h001;
          if (len_r == 12'h001) begin
            cle_nxt   = 1'b1;
            io_nxt    = IO_W'(OPC_PROG2);
            we_n_nxt  = 1'b0;
            ph_nxt    = 1'b0;
            cnt_nxt   = STROBE_CYC - 8'h01;
            state_nxt = S_CMD2;
          end else begin
            state_nxt = S_WFETCH;
          end
        end
      end
      S_CMD2: begin
        if (wcyc_done) begin
          cle_nxt   = 1'b0;
          oe_nxt    = 1'b0;
          cnt_nxt   = WB_CYC - 8'h01;
          state_nxt = S_WB;
        end
      end
      S_WB: begin
        // busy is not yet valid until the assertion delay is over
        if (tmr_zero) begin
          state_nxt = S_BUSY;
        end
      end
      S_BUSY: begin
        if (rb_s2_r) begin
          if (cmd_r.op == OP_PAGE_READ) begin
            cnt_nxt   = WHR_CYC - 8'h01;
            state_nxt = S_GAP;
          end else begin
            state_nxt = S_DONE;
          end
        end
      end
      S_GAP: begin
        if (tmr_zero) begin
          re_n_nxt  = 1'b0;
          ph_nxt    = 1'b0;
          cnt_nxt   = RLOW_CYC - 8'h01;
          state_nxt = S_RDATA;
        end
      end
      S_RDATA: begin
        if (tmr_zero && !ph_r) begin
          rd_nxt   = io_s2_r;
          rdv_nxt  = 1'b1;
          re_n_nxt = 1'b1;
          ph_nxt   = 1'b1;
          cnt_nxt  = STROBE_CYC - 8'h01;
        end else if (tmr_zero) begin
          len_nxt = len_r - 12'h001;
          if (len_r == 12'h001) begin
            state_nxt = S_DONE;
          end else begin
            re_n_nxt = 1'b0;
            ph_nxt   = 1'b0;
            cnt_nxt  = RLOW_CYC - 8'h01;
          end
        end
      end
      S_DONE: begin
        ce_n_nxt  = 1'b1;
        wp_n_nxt  = 1'b0;
        done_nxt  = 1'b1;
        state_nxt = S_IDLE;
      end
    endcase
  end

  // *****************************************************
  // registers
  // *****************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= S_IDLE;
      cmd_r   <= '0;
      cnt_r   <= 8'h00;
      ph_r    <= 1'b0;
      idx_r   <= 3'h0;
      len_r   <= 12'h000;
      ce_n_r  <= 1'b1;
      cle_r   <= 1'b0;
      ale_r   <= 1'b0;
      we_n_r  <= 1'b1;
      re_n_r  <= 1'b1;
      wp_n_r  <= 1'b0;
      oe_r    <= 1'b0;
      io_r    <= '0;
      rd_r    <= '0;
      rdv_r   <= 1'b0;
      done_r  <= 1'b0;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      io_s1_r <= '0;
      io_s2_r <= '0;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      cnt_r   <= cnt_nxt;
      ph_r    <= ph_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      ce_n_r  <= ce_n_nxt;
      cle_r   <= cle_nxt;
      ale_r   <= ale_nxt;
      we_n_r  <= we_n_nxt;
      re_n_r  <= re_n_nxt;
      wp_n_r  <= wp_n_nxt;
      oe_r    <= oe_nxt;
      io_r    <= io_nxt;
      rd_r    <= rd_nxt;
      rdv_r   <= rdv_nxt;
      done_r  <= done_nxt;
      rb_s1_r <= i_ready_busy_n;
      rb_s2_r <= rb_s1_r;
      io_s1_r <= i_io_in;
      io_s2_r <= io_s1_r;
    end
  end

  assign o_ce_n          = ce_n_r;
  assign o_cle           = cle_r;
  assign o_ale           = ale_r;
  assign o_we_n          = we_n_r;
  assign o_read_strobe_n = re_n_r;
  assign o_wp_n          = wp_n_r;
  assign o_io_out        = io_r;
  assign o_io_oe         = oe_r;
  assign o_rd_data       = rd_r;
  assign o_rd_valid      = rdv_r;
  assign o_done          = done_r;
endmodule // nand_host

// ---- nand_host_pkg.sv ----
// shared constants and types of the nand bus host controller
package nand_host_pkg;
  // *****************************************************
  // timing
  // *****************************************************
  localparam int CLK_NS    = 5;    // 200 MHz system clock
  localparam int STROBE_NS = 25;   // each strobe phase, low and high
  localparam int TWB_NS    = 100;  // strobe to busy assertion
  localparam int TWHR_NS   = 60;   // turnaround before reading
  localparam int SYNC_CYC  = 2;    // pin synchroniser latency
  // least times round up
  localparam logic [7:0] STROBE_CYC =
    8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WB_CYC   = 8'((TWB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WHR_CYC  = 8'((TWHR_NS + CLK_NS - 1) / CLK_NS);
  // read low time covers the synchroniser delay on returning data
  localparam logic [7:0] RLOW_CYC = 8'(int'(STROBE_CYC) + SYNC_CYC);
  localparam int FIFO_DEPTH = 8;
  // *****************************************************
  // opcodes
  // *****************************************************
  localparam logic [7:0] OPC_READ1   = 8'h00;
  localparam logic [7:0] OPC_READ2   = 8'h30;
  localparam logic [7:0] OPC_READ_ID = 8'h90;
  localparam logic [7:0] OPC_STATUS  = 8'h70;
  localparam logic [7:0] OPC_RESET   = 8'hFF;
  localparam logic [7:0] OPC_PROG1   = 8'h80;
  localparam logic [7:0] OPC_PROG2   = 8'h10;
  localparam logic [7:0] OPC_ERASE1  = 8'h60;
  localparam logic [7:0] OPC_ERASE2  = 8'hD0;
  localparam logic [7:0] ID_ADDR     = 8'h00;  // id address cycle
  localparam logic [11:0] ID_LEN     = 12'h005; // id bytes read
  localparam logic [11:0] STATUS_LEN = 12'h001;
  // address cycle indices
  localparam logic [2:0] ADDR_FIRST = 3'h0;
  localparam logic [2:0] ROW_FIRST  = 3'h2;
  localparam logic [2:0] ADDR_LAST  = 3'h4;
  // *****************************************************
  // types
  // *****************************************************
  typedef enum logic [2:0] {
    OP_PAGE_READ, OP_PROGRAM, OP_ERASE, OP_STATUS, OP_READ_ID, OP_RESET
  } op_e;
  typedef struct packed {
    op_e         op;
    logic [11:0] col;   // column, bit 11 unused in word mode
    logic [17:0] row;   // row, plane select is row bit 6
    logic [11:0] len;   // words moved by read or program, at least 1
  } cmd_s;
endpackage

// ---- nand_host_monitor.sv ----
// assertion checker on the nand host controller pins
`timescale 1ns/100ps
module nand_host_monitor import nand_host_pkg::*; #(
  parameter int IO_W = 8
) (
  input wire logic            i_clk,
  input wire logic            i_reset,
  input wire logic            i_cmd_valid,
  input wire logic            o_cmd_ready,
  input wire cmd_s            i_cmd,
  input wire logic            o_done,
  input wire logic            i_wr_valid,
  input wire logic            o_wr_ready,
  input wire logic [IO_W-1:0] i_wr_data,
  input wire logic            o_rd_valid,
  input wire logic [IO_W-1:0] o_rd_data,
  input wire logic            o_ce_n,
  input wire logic            o_cle,
  input wire logic            o_ale,
  input wire logic            o_we_n,
  input wire logic            o_read_strobe_n,
  input wire logic            o_wp_n,
  input wire logic [IO_W-1:0] o_io_out,
  input wire logic            o_io_oe,
  input wire logic [IO_W-1:0] i_io_in,
  input wire logic            i_ready_busy_n
);
  // ****
  // pin protocol checks
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // a request is taken only in idle
  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence
  // write strobe low 5 cycles in all
  sequence s_we_rest;
    !o_we_n [*4] ##1 o_we_n;
  endsequence
  // read strobe low 7 cycles, covers synchroniser delay
  sequence s_rs_rest;
    !o_read_strobe_n [*6] ##1 o_read_strobe_n;
  endsequence
  chk_take_starts_cmd: assert property (
    s_take |=> !o_ce_n && o_cle && !o_cmd_ready) else $error("take");
  chk_we_width: assert property (
    $fell(o_we_n) |=> s_we_rest) else $error("we width");
  chk_latch_stable: assert property ($rose(o_we_n) |->
    $stable(o_io_out) && $stable(o_cle) && $stable(o_ale))
    else $error("latch hold");
  chk_read_width: assert property (
    $fell(o_read_strobe_n) |=> s_rs_rest) else $error("read width");
  chk_read_word: assert property (
    $rose(o_read_strobe_n) |-> o_rd_valid) else $error("read word");
  chk_latch_excl: assert property (
    !(o_cle && o_ale)) else $error("cle and ale");
  chk_drive_input: assert property (
    !o_we_n |-> o_io_oe && !o_ce_n) else $error("input drive");
  chk_no_drive_read: assert property (
    !o_read_strobe_n |-> !o_io_oe && o_we_n) else $error("read drive");
  chk_busy_quiet: assert property (
    (!i_ready_busy_n) [*3] |-> o_we_n && o_read_strobe_n)
    else $error("strobe while busy");
  chk_idle_deselect: assert property (
    o_cmd_ready [*3] |-> o_ce_n) else $error("idle select");
  chk_idle_protect: assert property (
    o_cmd_ready [*3] |-> !o_wp_n) else $error("idle protect");
  // a new request may be taken in the done cycle itself, so chip select
  // is checked while done stands rather than one cycle later
  chk_done_pulse: assert property (
    o_done |-> o_ce_n ##1 !o_done) else $error("done pulse");
endmodule // nand_host_monitor

bind nand_host nand_host_monitor #(.IO_W(IO_W)) mon (.i_clk, .i_reset,
  .i_cmd_valid, .o_cmd_ready, .i_cmd, .o_done, .i_wr_valid, .o_wr_ready,
  .i_wr_data, .o_rd_valid, .o_rd_data, .o_ce_n, .o_cle, .o_ale, .o_we_n,
  .o_read_strobe_n, .o_wp_n, .o_io_out, .o_io_oe, .i_io_in,
  .i_ready_busy_n);

// ---- nand_dev_model.sv ----
// behavioural byte-wide nand device facing the host controller
`timescale 1ns/100ps
module nand_dev_model #(
  parameter logic [7:0] ID_BYTE = 8'h5A, // arbitrary id value
  parameter int         BUSY_NS = 400
) (
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_io,
  output logic [7:0]      o_io,
  output logic            o_pull_low
);
  // ****
  // latches and array state
  // ****
  logic [7:0]  cmd_r = 8'h00;   // read opcode latched at power-up
  logic [7:0]  addr_q [5];
  int          n_addr = 0;
  int          n_wr = 0;
  int          n_prog = 0;
  logic [7:0]  last_wr = 8'h00;
  logic [11:0] col = 12'h000;
  logic        plane = 1'h0;
  logic        busy = 1'h0;
  event        ev_go;
  assign o_pull_low = busy;     // open drain low while busy
  initial o_io = 8'h00;
  // busy starts a little after the closing opcode
  always begin
    @(ev_go);
    #50 busy = 1'h1;
    #(BUSY_NS) busy = 1'h0;
  end
  // all input cycles latch on strobe rise while selected
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle && !i_ale) begin // command cycle
      if (!busy || i_io == 8'h70 || i_io == 8'hFF) begin
        case (i_io)
          // plane and copy-back openers restart the address count
          8'h00, 8'h60, 8'h80, 8'h90, 8'h81, 8'h85, 8'h06: begin
            cmd_r = i_io;
            n_addr = 0;
            n_wr = 0;
          end
          8'h30, 8'h35: if (cmd_r == 8'h00) begin
            col = {addr_q[1][3:0], addr_q[0]};
            plane = addr_q[2][6];
            cmd_r = i_io;
            ->ev_go;
          end
          8'h10: if (cmd_r[7:4] == 4'h8 && i_wp_n) begin
            n_prog++;
            cmd_r = i_io;
            ->ev_go;
          end
          8'hD0: if (cmd_r == 8'h60 && i_wp_n) begin
            cmd_r = i_io;
            ->ev_go;
          end
          8'h70: cmd_r = i_io;
          8'h11, 8'hD1, 8'hE0: cmd_r = i_io;
          8'hFF: begin
            cmd_r = i_io;
            ->ev_go;
          end
          default: cmd_r = 8'h00; // broken sequence dropped
        endcase
      end
    end else if (!i_ce_n && i_ale && !i_cle) begin
      if (n_addr < 5) begin // surplus cycles ignored
        addr_q[n_addr] = i_io;
        n_addr++;
      end
    end else if (!i_ce_n && i_wp_n) begin // data input
      last_wr = i_io;
      n_wr++;
    end
  end
  // data out on strobe fall, column steps on rise
  always @(negedge i_read_strobe_n) begin
    if (!i_ce_n) begin
      o_io = (cmd_r == 8'h70) ? (busy ? 8'hA0 : 8'hE0) :
             (cmd_r == 8'h90) ? ID_BYTE : col[7:0];
    end
  end
  always @(posedge i_read_strobe_n) begin
    o_io = ~o_io; // released bus shows no stale value
    if (!i_ce_n && cmd_r == 8'h30) col = col + 12'h001;
  end
endmodule // nand_dev_model

// ---- testbench.sv ----
// self-checking bench for the nand host controller
`timescale 1ns/100ps
module testbench import nand_host_pkg::*;;
  // ****
  // signals, rows and tasks
  // ****
  localparam logic [7:0] ID_VAL = 8'h5A; // arbitrary id value
  typedef struct packed {
    cmd_s       c;
    logic [7:0] op2;  // last opcode the device should hold
    logic [2:0] na;   // address cycles, 0 for none
    logic [7:0] rd0;  // first word read back
    logic [3:0] nrd;  // words read back
  } row_s;
  row_s rows [5] = '{
    '{'{OP_STATUS, 12'h000, 18'h00000, 12'h001}, 8'h70, 3'h0, 8'hE0, 4'h1},
    '{'{OP_READ_ID, 12'h000, 18'h00000, 12'h001}, 8'h90, 3'h1, ID_VAL,
      4'h5},
    '{'{OP_PAGE_READ, 12'hABC, 18'h25841, 12'h003}, 8'h30, 3'h5, 8'hBC,
      4'h3},
    '{'{OP_ERASE, 12'h000, 18'h1FF3F, 12'h001}, 8'hD0, 3'h3, 8'h00, 4'h0},
    '{'{OP_RESET, 12'h000, 18'h00000, 12'h001}, 8'hFF, 3'h0, 8'h00, 4'h0}};
  cmd_s       pcmd = '{OP_PROGRAM, 12'h7FF, 18'h00040, 12'h009};
  logic       i_clk = 1'h0;
  logic       i_reset = 1'h1;
  logic       i_cmd_valid = 1'h0;
  cmd_s       i_cmd = '0;
  logic       i_wr_valid = 1'h0;
  logic [7:0] i_wr_data = 8'h00;
  wire  [7:0] i_io_in;
  wire        i_ready_busy_n;
  logic       o_cmd_ready, o_done, o_wr_ready, o_rd_valid, o_ce_n, o_cle;
  logic       o_ale, o_we_n, o_read_strobe_n, o_wp_n, o_io_oe, pull_low;
  logic [7:0] o_rd_data, o_io_out, dev_io;
  logic [7:0] rd_q [$];
  int         num_errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  assign i_io_in = o_io_oe ? o_io_out : dev_io;  // shared io wire
  assign i_ready_busy_n = pull_low ? 1'h0 : 1'h1; // pull-up
  always #2.5 i_clk = ~i_clk;
  nand_host #(.IO_W(8)) dut (.i_clk, .i_reset, .i_cmd_valid, .o_cmd_ready,
    .i_cmd, .o_done, .i_wr_valid, .o_wr_ready, .i_wr_data, .o_rd_valid,
    .o_rd_data, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_read_strobe_n,
    .o_wp_n, .o_io_out, .o_io_oe, .i_io_in, .i_ready_busy_n);
  nand_dev_model #(.ID_BYTE(ID_VAL)) model (.i_ce_n(o_ce_n), .i_cle(o_cle),
    .i_ale(o_ale), .i_we_n(o_we_n), .i_read_strobe_n(o_read_strobe_n),
    .i_wp_n(o_wp_n), .i_io(i_io_in), .o_io(dev_io), .o_pull_low(pull_low));
  // read words stand one cycle, so they are gathered on every edge
  always @(posedge i_clk) begin
    if (o_rd_valid === 1'h1) rd_q.push_back(o_rd_data);
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("ERROR timeout expected end seen hang");
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // bytes of the five-cycle address, erase uses the last three
  function automatic logic [7:0] exp_addr(cmd_s c, logic [2:0] na, int j);
    logic [39:0] b;
    b = {6'h00, c.row, 4'h0, c.col};
    if (na == 3'h1) return 8'h00;
    return b[8 * (j + 5 - int'(na)) +: 8];
  endfunction
  task automatic start_op(input cmd_s c);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'h1 && n < 100) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    i_cmd = c;
    i_cmd_valid = 1'h1;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'h0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (o_done !== 1'h1 && n < 9000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("done", 1, o_done);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_reset = 1'h0;
    foreach (rows[i]) begin
      rd_q.delete();
      start_op(rows[i].c);
      wait_done();
      check("ce_n", 1, o_ce_n);
      check("opcode", rows[i].op2, model.cmd_r);
      check("reads", rows[i].nrd, rd_q.size());
      foreach (rd_q[k]) check("word", rows[i].rd0 + 8'(
        rows[i].c.op == OP_PAGE_READ ? k : 0), rd_q[k]);
      for (int j = 0; j < int'(rows[i].na); j++)
        check("addr", exp_addr(rows[i].c, rows[i].na, j),
          model.addr_q[j]);
      if (rows[i].na != 3'h0)
        check("n_addr", rows[i].na, model.n_addr);
      if (rows[i].c.op == OP_PAGE_READ)
        check("plane", rows[i].c.row[6], model.plane);
      $display("row %0d done", i);
    end
    // fill the fifo until it refuses; the ninth word comes late
    for (int k = 0; k < 9; k++) begin
      i_wr_data = 8'hA0 + 8'(k);
      i_wr_valid = 1'h1;
      @(posedge i_clk);
      #1;
    end
    check("fifo full", 0, o_wr_ready);
    i_wr_valid = 1'h0;
    start_op(pcmd);
    repeat (300) @(posedge i_clk);
    #1;
    check("stalled words", 8, model.n_wr);
    i_wr_valid = 1'h1;
    @(posedge i_clk);
    #1;
    i_wr_valid = 1'h0;
    wait_done();
    check("words", 9, model.n_wr);
    check("last word", 8'hA8, model.last_wr);
    check("programs", 1, model.n_prog);
    for (int j = 0; j < 5; j++)
      check("prog addr", exp_addr(pcmd, 3'h5, j), model.addr_q[j]);
    $display("program test done");
    // reset in mid-address, then a status read must still work
    start_op(rows[2].c);
    repeat (40) @(posedge i_clk);
    #1;
    i_reset = 1'h1;
    #1;
    check("reset ce_n", 1, o_ce_n);
    check("reset wp_n", 0, o_wp_n);
    check("reset oe", 0, o_io_oe);
    @(posedge i_clk);
    #1;
    i_reset = 1'h0;
    rd_q.delete();
    start_op(rows[0].c);
    wait_done();
    check("status count", 1, rd_q.size());
    if (rd_q.size() > 0) check("status", 8'hE0, rd_q[0]);
    $display("reset test done");
    report_and_stop();
  end
endmodule // testbench
